// ==== dual_mod_engine.sv ====
`timescale 1ns/10ps
module dual_mod_engine
    import synth_div_pkg::*;
#(
    parameter int MAIN_W = 9,
    parameter int SWAL_W = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control and counts
    input wire logic enable,
    input wire logic presc_edge,
    input wire logic [MAIN_W-1:0] main_load,
    input wire logic [SWAL_W-1:0] swallow_load,
    // Prescaler and phase detector side
    output logic modulus_hi_q,
    output logic div_pulse_q
);

    eng_state_e state_q, state_d;
    logic [MAIN_W-1:0] main_q, main_d;
    logic [SWAL_W-1:0] swal_q, swal_d;
    logic pulse_d;

    // Count cycle sequencing, one step per prescaler edge
    always_comb begin
        state_d = state_q;
        main_d = main_q;
        swal_d = swal_q;
        pulse_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                main_d = '0;
                swal_d = '0;
                if (enable && presc_edge) begin
                    state_d = ST_RUN;
                    main_d = main_load;
                    swal_d = swallow_load;
                end
            end
            ST_RUN: begin
                if (!enable) begin
                    state_d = ST_IDLE;
                    main_d = '0;
                    swal_d = '0;
                end else if (presc_edge) begin
                    // Last of N periods ends the cycle
                    if (main_q <= MAIN_W'(1)) begin
                        pulse_d = 1'b1;
                        main_d = main_load;
                        swal_d = swallow_load;
                    end else begin
                        main_d = main_q - MAIN_W'(1);
                        if (swal_q != '0) begin
                            swal_d = swal_q - SWAL_W'(1);
                        end
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                main_d = '0;
                swal_d = '0;
            end
        endcase
    end

    // Counters and state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            main_q <= '0;
            swal_q <= '0;
        end else begin
            state_q <= state_d;
            main_q <= main_d;
            swal_q <= swal_d;
        end
    end

    // Modulus line follows the swallow count of the coming period
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            modulus_hi_q <= 1'b0;
            div_pulse_q <= 1'b0;
        end else begin
            modulus_hi_q <= (swal_d != '0);
            div_pulse_q <= pulse_d;
        end
    end

endmodule // dual_mod_engine

// ==== dual_modulus_synth_divider.sv ====
// Function
// - Modulus line asks base plus one while swallow count is nonzero, else base.
// - Main and swallow counters load together on one prescaler edge.
// - Total division is main times base plus swallow.
// - First loop prescaler divides by 32 or 33; base is 32.
// - First loop: ratio over 32 gives main count, remainder swallow count.
// - First oscillator target is channel plus 75.00 MHz.
// - Only the leading four channel digits feed the first target.
// - Leading channel digit is always the 10 MHz digit.
// - First loop covers 76.60 to 104.99 MHz in 10 kHz steps.
// - First loop reference and step are 10 kHz.
// - Second loop uses 64/65 prescaler, main count fixed at 11459.
// - Second swallow count is 124 minus 1 kHz and 100 Hz digit pair.
// - Second swallow count spans 25 to 124; status only flags counts outside 1 to 100.
// - Second loop spans 10 kHz in 100 Hz steps, output ratio times 100 Hz.
// - Second oscillator is first IF minus 1.65 MHz.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module dual_modulus_synth_divider
    import synth_div_pkg::*;
#(
    parameter int MAIN1_W = 9,
    parameter int SWAL1_W = 5,
    parameter int MAIN2_W = 14,
    parameter int SWAL2_W = 7
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    // First loop prescaler and phase detector
    input wire logic presc1_out,
    output logic presc1_mod,
    output logic pd1_div,
    // Second loop prescaler and phase detector
    input wire logic presc2_out,
    output logic presc2_mod,
    output logic pd2_div
);

    // Channel digits, most significant first, packed BCD
    function automatic logic [19:0] bcd_to_bin(
        input logic [23:0] bcd,
        input int ndig
    );
        logic [19:0] acc;
        acc = '0;
        for (int i = 5; i >= 0; i--) begin
            if (i < ndig) begin
                acc = 20'(acc * 20'h0000A + 20'(bcd[i*4 +: 4]));
            end
        end
        return acc;
    endfunction

    // Every nibble must be a decimal digit
    function automatic logic bcd_ok(input logic [23:0] bcd);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (bcd[i*4 +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // Swallow must run out before main does
    function automatic logic split_ok(
        input logic [13:0] main_cnt,
        input logic [13:0] swal_cnt
    );
        return main_cnt > swal_cnt;
    endfunction

    // Software state
    logic [23:0] chan_q;
    logic chan_new_q;
    logic [1:0] ctrl_q;
    logic [31:0] rdata_q;
    logic [31:0] read_word;

    // Applied counts, swapped in as one group
    logic [MAIN1_W-1:0] pend1_main_q;
    logic [SWAL1_W-1:0] pend1_swal_q;
    logic [SWAL2_W-1:0] pend2_swal_q;
    logic [13:0] osc1_q;
    logic [20:0] osc2_q;
    logic valid_q;
    logic refused_q;

    // Prescaler pin synchronisers
    logic p1_meta_q, p1_sync_q, p1_prev_q;
    logic p2_meta_q, p2_sync_q, p2_prev_q;
    logic p1_edge, p2_edge;

    // Arithmetic on the selected channel
    logic [19:0] lead4_w;
    logic [19:0] pair_w;
    logic [19:0] chan_units_w;
    logic [13:0] first_osc_target;
    logic [13:0] ratio1;
    logic [13:0] main1_w;
    logic [13:0] swal1_w;
    logic [6:0] sub_kilohertz_digit_pair;
    logic [6:0] swal2_w;
    logic [20:0] first_intermediate_freq;
    logic [20:0] second_osc_target;
    logic [20:0] loop2_ratio;
    logic range1_ok, sw2_ok, mains_ok, agree, chan_valid;

    // Channel register; the strobe marks a fresh value for checking
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_q <= CHAN_RST;
            chan_new_q <= 1'b0;
        end else begin
            chan_new_q <= 1'b0;
            if (bus_wr && bus_addr == CHAN_OFS) begin
                chan_q <= bus_wdata[23:0];
                chan_new_q <= 1'b1;
            end
        end
    end

    // Loop enables
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RST;
        end else if (bus_wr && bus_addr == CTRL_OFS) begin
            ctrl_q <= bus_wdata[1:0];
        end
    end

    // Leading digit is always tens of MHz, so 2 MHz arrives as 02.00
    assign lead4_w = bcd_to_bin({8'h00, chan_q[23:8]}, 4);
    assign pair_w = bcd_to_bin({16'h0000, chan_q[7:0]}, 2);
    assign chan_units_w = bcd_to_bin(chan_q, 6);

    // First loop target in 10 kHz units, which is also its ratio
    assign first_osc_target = lead4_w[13:0] + LO1_OFFSET_10K;
    assign ratio1 = first_osc_target;

    // Power-of-two base keeps the split a plain shift
    assign main1_w = ratio1 / LOOP1_BASE;
    assign swal1_w = ratio1 % LOOP1_BASE;

    // First loop tuning range check
    assign range1_ok = (first_osc_target >= LOOP1_MIN_10K) &&
                       (first_osc_target <= LOOP1_MAX_10K);

    // Second loop swallow count from the sub-10 kHz digits
    assign sub_kilohertz_digit_pair = pair_w[6:0];
    assign swal2_w = SW2_FROM - sub_kilohertz_digit_pair;
    assign sw2_ok = (swal2_w >= SW2_MIN) && (swal2_w <= SW2_MAX);

    // Frequency plan in 100 Hz units
    assign first_intermediate_freq =
        21'(first_osc_target) * STEPS_100HZ_PER_10K -
        21'(chan_units_w);
    assign second_osc_target =
        first_intermediate_freq - IF2_100HZ;
    assign loop2_ratio = 21'(LOOP2_MAIN) * LOOP2_BASE +
                         21'(swal2_w);
    assign agree = (loop2_ratio == second_osc_target);

    // A split with main not above swallow would never drop modulus
    assign mains_ok =
        split_ok(main1_w, swal1_w) &&
        split_ok(LOOP2_MAIN, 14'(swal2_w));
    assign chan_valid = bcd_ok(chan_q) && range1_ok && mains_ok;

    // Loop one split; engine picks it up only at its next reload
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend1_main_q <= '0;
            pend1_swal_q <= '0;
        end else if (chan_new_q && chan_valid) begin
            pend1_main_q <= main1_w[MAIN1_W-1:0];
            pend1_swal_q <= swal1_w[SWAL1_W-1:0];
        end
    end

    // Loop two swallow count; its main count never changes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend2_swal_q <= '0;
        end else if (chan_new_q && chan_valid) begin
            pend2_swal_q <= swal2_w[SWAL2_W-1:0];
        end
    end

    // Oscillator targets of the applied channel, for readback
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc1_q <= '0;
            osc2_q <= '0;
        end else if (chan_new_q && chan_valid) begin
            osc1_q <= first_osc_target;
            osc2_q <= loop2_ratio;
        end
    end

    // Engines stay idle until one good channel has been applied
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            valid_q <= 1'b0;
        end else if (chan_new_q && chan_valid) begin
            valid_q <= 1'b1;
        end
    end

    // Refused flag: set by a bad channel, cleared by a good one
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            refused_q <= 1'b0;
        end else if (chan_new_q) begin
            refused_q <= !chan_valid;
        end
    end

    // Loop one pin: two flops before any logic looks at it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            p1_meta_q <= 1'b0;
            p1_sync_q <= 1'b0;
            p1_prev_q <= 1'b0;
        end else begin
            p1_meta_q <= presc1_out;
            p1_sync_q <= p1_meta_q;
            p1_prev_q <= p1_sync_q;
        end
    end

    // Loop two pin, same treatment
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            p2_meta_q <= 1'b0;
            p2_sync_q <= 1'b0;
            p2_prev_q <= 1'b0;
        end else begin
            p2_meta_q <= presc2_out;
            p2_sync_q <= p2_meta_q;
            p2_prev_q <= p2_sync_q;
        end
    end

    // Loop one rising edge; pin must stay well under half sys_clk
    assign p1_edge = p1_sync_q && !p1_prev_q;

    // Loop two rising edge, same limit
    assign p2_edge = p2_sync_q && !p2_prev_q;

    // First loop divider, 32/33 prescaler
    dual_mod_engine #(
        .MAIN_W(MAIN1_W),
        .SWAL_W(SWAL1_W)
    ) u_loop1 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .enable(ctrl_q[CTRL_EN1_BIT] && valid_q),
        .presc_edge(p1_edge),
        .main_load(pend1_main_q),
        .swallow_load(pend1_swal_q),
        .modulus_hi_q(presc1_mod),
        .div_pulse_q(pd1_div)
    );

    // Second loop divider, 64/65 prescaler, main count fixed
    dual_mod_engine #(
        .MAIN_W(MAIN2_W),
        .SWAL_W(SWAL2_W)
    ) u_loop2 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .enable(ctrl_q[CTRL_EN2_BIT] && valid_q),
        .presc_edge(p2_edge),
        .main_load(LOOP2_MAIN[MAIN2_W-1:0]),
        .swallow_load(pend2_swal_q),
        .modulus_hi_q(presc2_mod),
        .div_pulse_q(pd2_div)
    );

    // Read decode; unmapped addresses read zero
    always_comb begin
        read_word = 32'h0000_0000;
        case (bus_addr)
            CHAN_OFS: begin
                read_word[23:0] = chan_q;
            end
            CTRL_OFS: begin
                read_word[1:0] = ctrl_q;
            end
            STAT_OFS: begin
                read_word[STAT_VALID_BIT] = valid_q;
                read_word[STAT_REFUSED_BIT] = refused_q;
                read_word[STAT_SW2_OK_BIT] = sw2_ok;
                read_word[STAT_AGREE_BIT] = agree;
            end
            LOOP1_OFS: begin
                read_word[CNT_MAIN_LSB +: MAIN1_W] = pend1_main_q;
                read_word[SWAL1_W-1:0] = pend1_swal_q;
            end
            LOOP2_OFS: begin
                read_word[CNT_MAIN_LSB +: MAIN2_W] =
                    LOOP2_MAIN[MAIN2_W-1:0];
                read_word[SWAL2_W-1:0] = pend2_swal_q;
            end
            OSC1_OFS: begin
                read_word[13:0] = osc1_q;
            end
            OSC2_OFS: begin
                read_word[20:0] = osc2_q;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_rd) begin
            rdata_q <= read_word;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign bus_rdata = rdata_q;

endmodule // dual_modulus_synth_divider

// ==== dual_modulus_synth_divider_tb.sv ====
`timescale 1ns/10ps
module dual_modulus_synth_divider_tb
    import synth_div_pkg::*;
;
    logic sys_clk, reset_n, bus_wr, bus_rd, run, slow1;
    logic [7:0] bus_addr, npd1, npd2;
    logic [31:0] bus_wdata, bus_rdata, tot1, tot2;
    logic presc1_out, presc1_mod, pd1_div, presc2_out, presc2_mod, pd2_div;
    int fail_count = 0;
    int cmp_count = 0;
    // In range, main above swallow
    logic [23:0] chans [6] = '{24'h016000, 24'h020000, 24'h020059,
        24'h250000, 24'h299999, 24'h091242};

    dual_modulus_synth_divider i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .presc1_out(presc1_out),
        .presc1_mod(presc1_mod), .pd1_div(pd1_div), .presc2_out(presc2_out),
        .presc2_mod(presc2_mod), .pd2_div(pd2_div));
    presc_model #(.BASE(32'h20), .HALF(32'h4)) i_presc1 (
        .sys_clk(sys_clk), .reset_n(reset_n), .run(run), .slow(slow1),
        .mod(presc1_mod), .pd(pd1_div), .pin(presc1_out), .total(tot1),
        .n_pd(npd1));
    presc_model #(.BASE(32'h40), .HALF(32'h3)) i_presc2 (
        .sys_clk(sys_clk), .reset_n(reset_n), .run(run), .slow(1'b0),
        .mod(presc2_mod), .pd(pd2_div), .pin(presc2_out), .total(tot2),
        .n_pd(npd2));

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    // Read data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
        d = bus_rdata;
        @(posedge sys_clk);
    endtask

    task automatic wait_pd(input int which, input logic [7:0] n);
        for (int i = 0; i < 80000 && (which == 1 ? npd1 : npd2) != n; i++)
            @(posedge sys_clk);
        check(which == 1 ? npd1 : npd2, n);
    endtask

    // First target in 10 kHz units from the top four digits
    function automatic int tgt(input logic [23:0] c);
        return 32'h1D4C + 32'h3E8 * c[23:20] + 32'h64 * c[19:16]
            + 32'hA * c[15:12] + c[11:8];
    endfunction

    task automatic t_regs();
        logic [31:0] d;
        rd(CHAN_OFS, d);
        check(d, 32'h020000);
        rd(CTRL_OFS, d);
        check(d, 32'h0);
        rd(8'h1C, d);
        check(d, 32'h0);
    endtask

    task automatic t_apply(input logic [23:0] c);
        logic [31:0] d;
        int t, a;
        t = tgt(c);
        a = 32'h7C - 32'hA * c[7:4] - c[3:0];
        wr(CHAN_OFS, {8'h00, c});
        repeat (2) @(posedge sys_clk);
        rd(OSC1_OFS, d);
        check(d, t);
        rd(LOOP1_OFS, d);
        check(d, ((t / 32'h20) << 16) | (t % 32'h20));
        rd(LOOP2_OFS, d);
        check(d, (32'h2CC3 << 16) | a);
        rd(OSC2_OFS, d);
        check(d, 32'h40 * 32'h2CC3 + a);
        rd(STAT_OFS, d);
        check(d, {28'h0, 1'b1, a >= 1 && a <= 100, 2'b01});
    endtask

    // Bad channel is flagged and the old counts stay in force
    task automatic t_refuse(input logic [23:0] c);
        logic [31:0] d;
        wr(CHAN_OFS, {8'h00, c});
        repeat (2) @(posedge sys_clk);
        rd(STAT_OFS, d);
        check(d & 32'h3, 32'h3);
        rd(LOOP1_OFS, d);
        check(d, 32'h0106001C);
    endtask

    task automatic t_run();
        logic [31:0] d;
        logic [7:0] n;
        wr(CTRL_OFS, 32'h3);
        run <= 1'b1;
        wait_pd(1, 8'h01);
        check(tot1, 32'h20DC);
        wr(CHAN_OFS, 32'h250000);
        wait_pd(1, 8'h02);
        check(tot1, 32'h20DC);
        slow1 <= 1'b1;
        wait_pd(1, 8'h03);
        check(tot1, 32'h2710);
        wait_pd(2, 8'h01);
        check(tot2, 32'hB3112);
        wr(LOOP1_OFS, 32'h0);
        rd(LOOP1_OFS, d);
        check(d, 32'h01380010);
        wr(CTRL_OFS, 32'h2);
        repeat (4) @(posedge sys_clk);
        n = npd1;
        repeat (200) @(posedge sys_clk);
        check({npd1, 7'h0, presc1_mod}, {n, 8'h00});
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog; the longest wait is one full second-loop cycle
    initial begin
        repeat (90000) @(posedge sys_clk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        {bus_wr, bus_rd, run, slow1} = 4'h0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        foreach (chans[i])
            t_apply(chans[i]);
        t_refuse(24'h300000);
        t_refuse(24'h015999);
        t_refuse(24'h0A0000);
        t_apply(24'h091242);
        t_run();
        report_and_stop();
    end
endmodule // dual_modulus_synth_divider_tb

// ==== presc_model.sv ====
`timescale 1ns/10ps
module presc_model #(
    parameter int BASE = 32,
    parameter int HALF = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Test control
    input wire logic run,
    input wire logic slow,
    // Divider side
    input wire logic mod,
    input wire logic pd,
    output logic pin,
    // Oscillator cycles counted over the last full count cycle
    output logic [31:0] total,
    output logic [7:0] n_pd
);
    logic [7:0] ph_q, half_q;
    logic [31:0] acc_q;
    logic armed_q;

    // Output wave; rises only at a period start, so no short first period
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_q <= 8'h00;
            half_q <= 8'(HALF);
            pin <= 1'b0;
        end else begin
            if (ph_q == 8'h00)
                half_q <= slow ? 8'(2 * HALF) : 8'(HALF);
            ph_q <= (ph_q + 8'h01 >= 2 * half_q) ? 8'h00 : ph_q + 8'h01;
            pin <= run && (ph_q == 8'h00 || (pin && ph_q < half_q));
        end
    end

    // Each rising edge after the first closes one period of base or base plus one
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= 32'h0;
            armed_q <= 1'b0;
            total <= 32'h0;
            n_pd <= 8'h00;
        end else begin
            if (run && ph_q == 8'h00) begin
                armed_q <= 1'b1;
                if (armed_q)
                    acc_q <= acc_q + 32'(BASE) + 32'(mod);
            end
            if (pd) begin
                total <= acc_q;
                acc_q <= 32'h0;
                n_pd <= n_pd + 8'h01;
            end
        end
    end
endmodule // presc_model

// ==== synth_div_chk.sv ====
`timescale 1ns/10ps
module synth_div_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Prescaler and phase detector pins
    input wire logic presc1_out,
    input wire logic presc1_mod,
    input wire logic pd1_div,
    input wire logic presc2_out,
    input wire logic presc2_mod,
    input wire logic pd2_div
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    logic [3:0] age1_q, age2_q;
    logic last1_q, last2_q;

    // Cycles since each prescaler pin rose; saturates so idle is obvious
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            age1_q <= 4'hF;
            age2_q <= 4'hF;
            last1_q <= 1'b0;
            last2_q <= 1'b0;
        end else begin
            last1_q <= presc1_out;
            last2_q <= presc2_out;
            age1_q <= (presc1_out && !last1_q) ? 4'h0 :
                age1_q + 4'(age1_q != 4'hF);
            age2_q <= (presc2_out && !last2_q) ? 4'h0 :
                age2_q + 4'(age2_q != 4'hF);
        end
    end

    property p_pd1_gap;
        pd1_div |=> !pd1_div [*7];
    endproperty
    a_pd1_gap: assert property (p_pd1_gap)
        else $error("pd1 pulse too long or too close");
    property p_pd2_gap;
        pd2_div |=> !pd2_div [*7];
    endproperty
    a_pd2_gap: assert property (p_pd2_gap)
        else $error("pd2 pulse too long or too close");
    property p_pd1_edge;
        pd1_div |-> age1_q inside {[4'h2:4'h7]};
    endproperty
    a_pd1_edge: assert property (p_pd1_edge)
        else $error("pd1 pulse not tied to a prescaler edge");
    property p_pd2_edge;
        pd2_div |-> age2_q inside {[4'h2:4'h7]};
    endproperty
    a_pd2_edge: assert property (p_pd2_edge)
        else $error("pd2 pulse not tied to a prescaler edge");
    property p_pd2_reload;
        pd2_div |-> presc2_mod;
    endproperty
    a_pd2_reload: assert property (p_pd2_reload)
        else $error("second modulus not high at reload");
    property p_mod1_rise;
        $rose(presc1_mod) |-> age1_q inside {[4'h2:4'h7]};
    endproperty
    a_mod1_rise: assert property (p_mod1_rise)
        else $error("first modulus rose without an edge");
    property p_mod2_rise;
        $rose(presc2_mod) |-> age2_q inside {[4'h2:4'h7]};
    endproperty
    a_mod2_rise: assert property (p_mod2_rise)
        else $error("second modulus rose without an edge");
    property p_mod2_fall;
        $fell(presc2_mod) |-> age2_q inside {[4'h2:4'h7]} && !pd2_div;
    endproperty
    a_mod2_fall: assert property (p_mod2_fall)
        else $error("second modulus fell off a count step");

    // Main scenarios reached
    c_pd1: cover property (pd1_div);
    c_pd2: cover property (pd2_div);
    c_swal1_end: cover property ($fell(presc1_mod));
endmodule // synth_div_chk

bind dual_modulus_synth_divider synth_div_chk i_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .presc1_out(presc1_out),
    .presc1_mod(presc1_mod), .pd1_div(pd1_div), .presc2_out(presc2_out),
    .presc2_mod(presc2_mod), .pd2_div(pd2_div)
);

// ==== synth_div_pkg.sv ====
package synth_div_pkg;

    // Register byte offsets on the plain register port
    localparam logic [7:0] CHAN_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] LOOP1_OFS = 8'h0C;
    localparam logic [7:0] LOOP2_OFS = 8'h10;
    localparam logic [7:0] OSC1_OFS = 8'h14;
    localparam logic [7:0] OSC2_OFS = 8'h18;

    // Reset values
    localparam logic [23:0] CHAN_RST = 24'h020000;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Field positions
    localparam int CTRL_EN1_BIT = 0;
    localparam int CTRL_EN2_BIT = 1;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_SW2_OK_BIT = 2;
    localparam int STAT_AGREE_BIT = 3;
    localparam int CNT_MAIN_LSB = 16;

    // First loop: 32/33 prescaler, 10 kHz reference and step
    localparam logic [13:0] LOOP1_BASE = 14'h0020;
    localparam logic [13:0] LO1_OFFSET_10K = 14'h1D4C;
    localparam logic [13:0] LOOP1_MIN_10K = 14'h1DEC;
    localparam logic [13:0] LOOP1_MAX_10K = 14'h2903;
    localparam logic [20:0] STEPS_100HZ_PER_10K = 21'h000064;

    // Second loop: 64/65 prescaler, fixed main count, 100 Hz ref
    localparam logic [20:0] LOOP2_BASE = 21'h000040;
    localparam logic [13:0] LOOP2_MAIN = 14'h2CC3;
    localparam logic [6:0] SW2_FROM = 7'h7C;
    localparam logic [6:0] SW2_MIN = 7'h01;
    localparam logic [6:0] SW2_MAX = 7'h64;
    localparam logic [20:0] IF2_100HZ = 21'h004074;

    // Divider engine states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } eng_state_e;

endpackage
